/* flic_pkg.sv */
// Summary of operation
// - Two priority bits select levels zero to three.
// - Only strictly higher level preempts; three never.
// - Simultaneous different levels: higher level served first.
// - Fixed ranking breaks ties within one level.
// - Ranking: ext0, timers, serials, twowire ... watchdog last.
// - Vectors 0003h stepping eight; reset uses 0000h.
// - Enable bits mapped across two registers plus two.
// - Priority bits share enable position for every source.
// - Flags cleared by hardware, software, or either.
// - Only listed sources may wake from stop.
// - Comparator wakes stop only in level mode.
// - All sources sampled into flags every cycle.
// - Poll, respond, save, load: four clocks minimum.
// - Active equal or higher service delays new entry.
// - Qualified requests OR into one core request.
// - Wake-capable sources limited to the fixed set.
// - Core request also wakes from idle.
// - Separate stop wake signal for stop and sleep.
// - Global enable gates every source enable for the core request; stop wake ignores it.
// - No dispatch until one instruction after return/config.
package flic_pkg;
	localparam int NSRC = 16;
	// Source index equals ranking position minus one.
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_CMP = 4'hc;
	// Sources whose enable and priority bits live in group 1.
	localparam logic [15:0] SRC_IN_GROUP1 = 16'hb7c0;
	// Bit position of each source inside its group, source 15 first.
	localparam logic [47:0] SRC_POS = {3'd7, 3'd6, 3'd6, 3'd2, 3'd7, 3'd3, 3'd5, 3'd1,
		3'd4, 3'd0, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0};
	// Flags that the controller clears when their vector is taken.
	localparam logic [15:0] HW_CLR_MASK = 16'hfe8f;
	// Flags that software is allowed to clear.
	localparam logic [15:0] SW_CLR_MASK = 16'hf7fa;
	// Sources able to raise the stop wake signal.
	localparam logic [15:0] STOP_WAKE_MASK = 16'hf285;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam logic [3:0] SVC_RESET = 4'h0;
	localparam int ENTRY_CYCLES = 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_POLL,
		ST_RESP,
		ST_SAVE,
		ST_LOAD
	} flic_state_e;
endpackage

/* flic_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module flic_flags import flic_pkg::*; (
	input wire logic mclk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [15:0] src_in, // Raw source events, ranking order.
	input wire logic [15:0] sw_clr, // Software clear requests.
	input wire logic [15:0] ack_onehot, // Source whose vector is loaded.
	output logic [15:0] flag // Pending flags.
);
	typedef struct packed {
		logic [15:0] flag;
	} flic_flags_s;
	flic_flags_s r_r;
	flic_flags_s r_nxt;
	logic [15:0] clr;

	// Every source is sampled each cycle; a set in the clearing cycle wins.
	always_comb begin
		clr = (sw_clr & SW_CLR_MASK) | (ack_onehot & HW_CLR_MASK);
		r_nxt.flag = src_in | (r_r.flag & ~clr);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_r.flag <= FLAG_RESET;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign flag = r_r.flag;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	flag_sample_a: assert property ((flag & $past(src_in)) == $past(src_in))
		else $error("source event not captured in flag");
endmodule
`default_nettype wire

/* flic_arb.sv */
`timescale 1ns/10ps
`default_nettype none
module flic_arb import flic_pkg::*; (
	input wire logic mclk, // System clock, assertions only.
	input wire logic rst_n, // Reset, assertions only.
	input wire logic [15:0] req, // Qualified requests.
	input wire logic [31:0] lvl, // Two-bit level per source.
	output logic win_valid, // Some request present.
	output logic [3:0] win_idx, // Winning source.
	output logic [1:0] win_lvl // Level of the winner.
);
	// Scan from lowest rank up so an equal level keeps the better rank.
	always_comb begin
		win_valid = 1'b0;
		win_idx = 4'h0;
		win_lvl = 2'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i] && (!win_valid || lvl[2*i+:2] >= win_lvl)) begin
				win_valid = 1'b1;
				win_idx = 4'(i);
				win_lvl = lvl[2*i+:2];
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	arb_req_a: assert property (win_valid |-> req[win_idx])
		else $error("winner is not requesting");
	arb_valid_a: assert property (win_valid == (|req))
		else $error("winner valid does not follow requests");
endmodule
`default_nettype wire

/* flic_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module flic_ctrl import flic_pkg::*; (
	input wire logic mclk, // System clock, 10 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [15:0] src_in, // Source events in ranking order.
	input wire logic [15:0] sw_clr, // Software flag clears.
	input wire logic [6:0] enable_register0_or_ext0_flag, // Enable register 0.
	input wire logic [6:0] enable_register1_or_ext1_flag, // Enable register 1.
	input wire logic nv_write_done_enable, // Write-done enable.
	input wire logic watchdog_irq_enable, // Watchdog enable.
	input wire logic global_irq_enable, // Global enable.
	input wire logic [7:0] priority_low_group0, // Low priority bits, group 0.
	input wire logic [7:0] priority_high_group0, // High priority bits, group 0.
	input wire logic [7:0] priority_low_group1, // Low priority bits, group 1.
	input wire logic [7:0] priority_high_group1, // High priority bits, group 1.
	input wire logic cmp_level_mode, // Comparator uses level events.
	input wire logic insn_end, // Last cycle of an instruction.
	input wire logic reti, // Return from service, in its last cycle.
	input wire logic cfg_access, // Enable or priority access, last cycle.
	output logic int_req, // Combined request, also idle wake.
	output logic stop_wake, // Stop and sleep wake.
	output logic core_respond, // Entry cycle two.
	output logic ctx_save, // Entry cycle three.
	output logic vec_load, // Entry cycle four, vector valid.
	output logic [15:0] vector, // Service vector address.
	output logic [15:0] pend_flag, // Pending flags for reading.
	output logic [3:0] svc_active // Levels in service.
);
	typedef struct packed {
		flic_state_e st;
		logic [3:0] idx;
		logic [1:0] lvl;
		logic [3:0] svc;
		logic hold;
		logic [15:0] vec;
	} flic_ctrl_s;
	flic_ctrl_s r_r;
	flic_ctrl_s r_nxt;

	logic [15:0] flag;
	logic [15:0] en_src;
	logic [15:0] qual;
	logic [31:0] lvl_src;
	logic [7:0] en_g0;
	logic [7:0] en_g1;
	logic [15:0] ack_onehot;
	logic win_valid;
	logic [3:0] win_idx;
	logic [1:0] win_lvl;
	logic can_take;

	// Picks a source's bit out of its group pair.
	function automatic logic pick(input logic [7:0] g0, input logic [7:0] g1, input int i);
		logic [2:0] pos;
		pos = SRC_POS[3*i+:3];
		pick = SRC_IN_GROUP1[i] ? g1[pos] : g0[pos];
	endfunction

	// Highest level currently in service.
	function automatic logic [1:0] top_lvl(input logic [3:0] svc);
		top_lvl = 2'h0;
		for (int k = 0; k < 4; k++) begin
			if (svc[k]) begin
				top_lvl = 2'(k);
			end
		end
	endfunction

	// Write-done and watchdog enables occupy bit 7 so that each enable
	// shares its position with the priority bits.
	assign en_g0 = {nv_write_done_enable, enable_register0_or_ext0_flag};
	assign en_g1 = {watchdog_irq_enable, enable_register1_or_ext1_flag};

	// Per-source enable and level.
	for (genvar i = 0; i < NSRC; i++) begin : g_src
		assign en_src[i] = pick(en_g0, en_g1, i);
		assign lvl_src[2*i+:2] = {pick(priority_high_group0, priority_high_group1, i),
			pick(priority_low_group0, priority_low_group1, i)};
	end

	// The global enable gates every source; the OR serves also as idle wake.
	assign qual = flag & en_src & {16{global_irq_enable}};
	assign int_req = |qual;

	// Stop wake ignores the global enable since the core is halted; the
	// comparator only counts when it produces level events.
	always_comb begin
		logic [15:0] wk;
		wk = flag & en_src & STOP_WAKE_MASK;
		wk[SRC_CMP] = wk[SRC_CMP] & cmp_level_mode;
		stop_wake = |wk;
	end

	flic_flags u_flags (
		.mclk(mclk),
		.rst_n(rst_n),
		.src_in(src_in),
		.sw_clr(sw_clr),
		.ack_onehot(ack_onehot),
		.flag(flag)
	);

	flic_arb u_arb (
		.mclk(mclk),
		.rst_n(rst_n),
		.req(qual),
		.lvl(lvl_src),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	// Entry is allowed at an instruction end, outside the hold after a
	// return or configuration access, and only above the active level.
	assign can_take = win_valid && insn_end && !r_r.hold && !reti && !cfg_access
		&& (r_r.svc == 4'h0 || win_lvl > top_lvl(r_r.svc));

	// Entry sequence, service bookkeeping and the hold after return.
	always_comb begin
		r_nxt = r_r;
		if (reti || cfg_access) begin
			r_nxt.hold = 1'b1;
		end else if (insn_end) begin
			r_nxt.hold = 1'b0;
		end
		if (reti && r_r.svc != 4'h0) begin
			r_nxt.svc[top_lvl(r_r.svc)] = 1'b0;
		end
		case (r_r.st)
			ST_IDLE: begin
				if (can_take) begin
					r_nxt.st = ST_POLL;
					r_nxt.idx = win_idx;
					r_nxt.lvl = win_lvl;
				end
			end
			ST_POLL: begin
				r_nxt.st = ST_RESP;
			end
			ST_RESP: begin
				r_nxt.st = ST_SAVE;
			end
			ST_SAVE: begin
				r_nxt.st = ST_LOAD;
				r_nxt.vec = VEC_BASE + {9'h000, r_r.idx, 3'h0};
			end
			ST_LOAD: begin
				r_nxt.st = ST_IDLE;
				r_nxt.svc[r_r.lvl] = 1'b1;
			end
			default: begin
				r_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_r.st <= ST_IDLE;
			r_r.idx <= 4'h0;
			r_r.lvl <= 2'h0;
			r_r.svc <= SVC_RESET;
			r_r.hold <= 1'b0;
			r_r.vec <= VEC_RESET;
		end else begin
			r_r <= r_nxt;
		end
	end

	// The taken source is cleared only if its flag is a hardware-clear type.
	assign ack_onehot = (r_r.st == ST_LOAD) ? (16'h0001 << r_r.idx) : 16'h0000;
	assign core_respond = (r_r.st == ST_RESP);
	assign ctx_save = (r_r.st == ST_SAVE);
	assign vec_load = (r_r.st == ST_LOAD);
	assign vector = r_r.vec;
	assign pend_flag = flag;
	assign svc_active = r_r.svc;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_entry;
		core_respond ##1 ctx_save ##1 vec_load;
	endsequence
	sequence s_quiet3;
		!core_respond [*3];
	endsequence
	sequence s_decide;
		r_r.st == ST_IDLE && can_take;
	endsequence

	global_gate_a: assert property (!global_irq_enable |-> !int_req)
		else $error("request raised with global enable clear");
	entry_seq_a: assert property ($rose(core_respond) |-> s_entry)
		else $error("entry steps out of order");
	entry_lat_a: assert property (core_respond |-> $past(insn_end, 2) && $past(int_req, 2))
		else $error("respond without request two cycles before");
	// The vector field is checked against the winner seen at the decision
	// edge, four samples back, rather than against the stored index.
	vec_addr_a: assert property (vec_load |-> vector[15:7] == 9'h000
		&& vector[6:3] == $past(win_idx, 4) && vector[2:0] == 3'h3)
		else $error("wrong vector address");
	no_preempt_a: assert property (core_respond |-> r_r.svc == 4'h0
		|| r_r.lvl > top_lvl(r_r.svc))
		else $error("preemption by equal or lower level");
	hold_after_a: assert property ((reti || cfg_access) |-> ##1 s_quiet3)
		else $error("dispatch too soon after return or access");
	svc_mark_a: assert property (vec_load |=> svc_active[$past(r_r.lvl)])
		else $error("service level not recorded");
	stop_src_a: assert property (stop_wake |-> |(flag & STOP_WAKE_MASK))
		else $error("stop wake from a non-wake source");
	cmp_wake_a: assert property (!cmp_level_mode && (flag & STOP_WAKE_MASK) == 16'h1000
		|-> !stop_wake)
		else $error("comparator edge event woke stop");

	// A decision at an idle instruction end is followed two cycles later by
	// the three entry steps, which gives the four-clock minimum from the flag.
	poll_step_a: assert property (s_decide |-> ##2 s_entry)
		else $error("entry steps do not follow the decision");

	// The three entry strobes never overlap.
	step_excl_a: assert property ($onehot0({core_respond, ctx_save, vec_load}))
		else $error("entry strobes overlap");

	// After a vector load the next response is at least three cycles away.
	entry_gap_a: assert property (vec_load |=> !core_respond [*2])
		else $error("new entry too soon after vector load");

	// No decision may be taken while the current instruction is still running.
	insn_gate_a: assert property (!insn_end |-> !can_take)
		else $error("decision inside an instruction");

	// The return or access cycle and the next one both refuse a decision;
	// this is what keeps a pending request from slipping in between.
	ret_gate_a: assert property ((reti || cfg_access) |-> !can_take ##1 !can_take)
		else $error("decision right after return or access");

	// A level-three service is never interrupted, whatever is pending.
	top_hold_a: assert property (svc_active[3] |-> !core_respond)
		else $error("level-three service preempted");

	// A return from a level-three service frees that level.
	ret_top_a: assert property (reti && r_r.svc[3] && !vec_load |=> !svc_active[3])
		else $error("return did not end the top service");

	// The vector only moves when a new one is loaded.
	vec_hold_a: assert property (!vec_load |-> $stable(vector))
		else $error("vector changed outside a load");

	// A taken hardware-clear flag drops, unless its source fires again in
	// that same cycle, in which case the new event must not be lost.
	hw_clear_a: assert property (vec_load && HW_CLR_MASK[r_r.idx] && !src_in[r_r.idx]
		|=> !pend_flag[$past(r_r.idx)])
		else $error("taken flag not cleared");

	// Flags that software may not clear only drop through an entry.
	sw_refuse_a: assert property (((~flag & $past(flag) & ~$past(ack_onehot))
		& ~SW_CLR_MASK) == 16'h0000)
		else $error("software cleared a protected flag");

	// Stop wake needs the source's own enable even with the global one clear.
	stop_en_a: assert property (stop_wake |-> |(flag & en_src & STOP_WAKE_MASK))
		else $error("stop wake from a disabled source");
endmodule
`default_nettype wire

/* flic_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Core model: an instruction ends every cycle unless the bench stalls it.
module flic_core_model (
	input wire logic mclk, // System clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic ret_req, // Bench asks for a return.
	input wire logic vec_load, // Vector strobe.
	input wire logic [15:0] vector, // Vector address.
	input wire logic insn_busy, // Bench stretches the current instruction.
	output logic insn_end, // Instruction boundary.
	output logic reti, // Return pulse.
	output logic [15:0] pc_r // Program counter after entry.
);
	assign insn_end = !insn_busy;
	// The counter takes the vector only on its strobe, never earlier.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reti <= 1'b0;
			pc_r <= 16'h0000;
		end else begin
			reti <= ret_req;
			if (vec_load)
				pc_r <= vector;
		end
	end
endmodule
`default_nettype wire

/* four_level_interrupt_controller_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module four_level_interrupt_controller_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic gie = 1'b0;
	logic cml = 1'b0;
	logic ret_req = 1'b0;
	logic cfg = 1'b0;
	logic busy = 1'b0;
	logic resp, save;
	logic en_nv = 1'b0;
	logic en_wd = 1'b0;
	logic [15:0] src = 16'h0000;
	logic [15:0] swc = 16'h0000;
	logic [6:0] en0 = 7'h00;
	logic [6:0] en1 = 7'h00;
	logic [7:0] pl0 = 8'h00;
	logic [7:0] ph0 = 8'h00;
	logic [7:0] pl1 = 8'h00;
	logic [7:0] ph1 = 8'h00;
	logic int_req, stop_wake, vec_load, insn_end, reti;
	logic [15:0] vector, pend_flag, pc_r;
	logic [3:0] svc_active;
	int n_errors = 0;
	int checked = 0;

	flic_ctrl dut (.mclk(mclk), .rst_n(rst_n), .src_in(src), .sw_clr(swc),
		.enable_register0_or_ext0_flag(en0), .enable_register1_or_ext1_flag(en1),
		.nv_write_done_enable(en_nv), .watchdog_irq_enable(en_wd), .global_irq_enable(gie),
		.priority_low_group0(pl0), .priority_high_group0(ph0), .priority_low_group1(pl1),
		.priority_high_group1(ph1), .cmp_level_mode(cml), .insn_end(insn_end), .reti(reti),
		.cfg_access(cfg), .int_req(int_req), .stop_wake(stop_wake), .core_respond(resp),
		.ctx_save(save), .vec_load(vec_load), .vector(vector), .pend_flag(pend_flag),
		.svc_active(svc_active));
	flic_core_model core (.mclk(mclk), .rst_n(rst_n), .ret_req(ret_req),
		.vec_load(vec_load), .vector(vector), .insn_busy(busy), .insn_end(insn_end),
		.reti(reti), .pc_r(pc_r));

	// The clock runs at 10 MHz.
	initial begin
		forever #50 mclk = ~mclk;
	end

	task end_of_test;
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A one-cycle event on the chosen sources, sampled at the following edge.
	task raise(input logic [15:0] m);
		@(posedge mclk);
		src <= m;
		@(posedge mclk);
		src <= 16'h0000;
		#1;
	endtask

	// Waits a bounded time for the vector strobe; a negative latency is not compared.
	task entry(input logic [15:0] exp_vec, input int exp_lat);
		int n;
		int nr;
		int ns;
		n = 0;
		nr = 0;
		ns = 0;
		#1;
		while (vec_load !== 1'b1 && n < 50) begin
			@(posedge mclk);
			#1;
			n++;
			if (resp === 1'b1)
				nr = n;
			if (save === 1'b1)
				ns = n;
		end
		if (exp_lat >= 0)
			chk(16'(n), 16'(exp_lat));
		chk(16'(nr), 16'(n - 2));
		chk(16'(ns), 16'(n - 1));
		@(posedge mclk);
		#1;
		chk(pc_r, exp_vec);
	endtask

	task ret;
		@(posedge mclk);
		ret_req <= 1'b1;
		@(posedge mclk);
		ret_req <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task clr;
		@(posedge mclk);
		swc <= 16'hffff;
		@(posedge mclk);
		swc <= 16'h0000;
	endtask

	task wake(input int idx, input logic mode, input logic exp);
		@(posedge mclk);
		cml <= mode;
		raise(16'h0001 << idx);
		chk({15'h0000, stop_wake}, {15'h0000, exp});
		chk({15'h0000, int_req}, 16'h0000);
		clr();
	endtask

	// Main sequence; the register model leaves the vector at zero in reset.
	initial begin
		repeat (9) @(posedge mclk);
		#1 chk(vector, 16'h0000);
		@(posedge mclk);
		rst_n <= 1'b1;
		en0 <= 7'h7f;
		en1 <= 7'h7f;
		en_nv <= 1'b1;
		en_wd <= 1'b1;
		gie <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			raise(16'h0001 << i);
			chk({15'h0000, int_req}, 16'h0001);
			entry(16'h0003 + 16'(8 * i), 4);
			chk(pend_flag & (16'h0001 << i), 16'h0170 & (16'h0001 << i));
			clr();
			ret();
		end
		// A configuration access in the decision cycle defers entry by two instructions.
		raise(16'h0002);
		cfg <= 1'b1;
		@(posedge mclk);
		cfg <= 1'b0;
		entry(16'h000b, 5);
		ret();
		// A stalled instruction keeps the request waiting for its last cycle.
		raise(16'h0002);
		busy <= 1'b1;
		repeat (3) @(posedge mclk);
		busy <= 1'b0;
		entry(16'h000b, 4);
		ret();
		raise(16'hffff);
		entry(16'h0003, -1);
		@(posedge mclk);
		pl0 <= 8'h02;
		entry(16'h000b, -1);
		@(posedge mclk);
		pl1 <= 8'h80;
		ph1 <= 8'h80;
		entry(16'h007b, -1);
		@(posedge mclk);
		pl0 <= 8'h03;
		ph0 <= 8'h01;
		raise(16'h0001);
		// A level-three service holds off even another level-three request.
		repeat (12) begin
			@(posedge mclk);
			#1 chk({15'h0000, vec_load}, 16'h0000);
		end
		gie <= 1'b0;
		ret();
		ret();
		ret();
		#1 chk({12'h000, svc_active}, 16'h0000);
		// A second reset drops the flags that only an entry can clear.
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		wake(7, 1'b0, 1'b1);
		wake(14, 1'b0, 1'b1);
		wake(1, 1'b0, 1'b0);
		wake(12, 1'b0, 1'b0);
		wake(12, 1'b1, 1'b1);
		// An enable that is clear keeps its source from waking stop.
		en1 <= 7'h6f;
		wake(7, 1'b0, 1'b0);
		// Software cannot clear the flags that only an entry clears.
		raise(16'h0805);
		clr();
		#1 chk(pend_flag, 16'h0805);
		end_of_test();
	end

	// The sequence needs well under 100 microseconds.
	initial begin
		#500000;
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
